// ===== rtl/amlfc_mode_low.sv
`timescale 1ns/1ps
module amlfc_mode_low (
	// Clock and reset.
	input wire logic clk,
	input wire logic srst,
	// Mode byte write from the serial interface.
	input wire logic mode_wr,
	input wire logic [7:0] mode_wdata,
	input wire logic polarity_unipolar,
	input wire logic [7:0] offset_dac,
	// Clock source strap and master clock.
	input wire logic clk_src_crystal,
	input wire logic mclk_in,
	// Decoded controls.
	output amlfc_pkg::amlfc_span_t input_range_select,
	output logic unipolar_coding,
	output logic offset_applied,
	output logic mclk_out,
	output logic conv_clock_run,
	output logic burnout_source_en,
	output logic burnout_sink_en,
	output logic [1:0] channel_select,
	output logic noise_short,
	output logic [1:0] cal_pair,
	output logic [7:0] mode_readback
);
	import amlfc_pkg::*;

	// ------------------------------------------------------------
	// Helpers.
	// ------------------------------------------------------------

	// Maps a channel code to its calibration pair.
	function automatic logic [1:0] pair_of(input logic [1:0] ch);
		unique case (ch)
			CHAN_PAIR0: pair_of = CAL_PAIR0;
			CHAN_PAIR1: pair_of = CAL_PAIR1;
			CHAN_NOISE: pair_of = CAL_PAIR0;
			CHAN_PAIR2: pair_of = CAL_PAIR2;
		endcase
	endfunction

	// Synchronisers for the clock source and master clock pins.
	logic [1:0] src_sync;
	logic [1:0] mclk_sync;
	logic [1:0] next_src_sync;
	logic [1:0] next_mclk_sync;

	// Stored fields.
	logic [1:0] range_q;
	logic clock_output_disable_q;
	logic burnout_q;
	logic [1:0] chan_q;
	logic [1:0] next_range_q;
	logic next_clock_output_disable_q;
	logic next_burnout_q;
	logic [1:0] next_chan_q;

	// Registered outputs' next values.
	amlfc_span_t next_input_range_select;
	logic next_unipolar_coding;
	logic next_offset_applied;
	logic next_mclk_out;
	logic next_conv_clock_run;
	logic next_burnout_source_en;
	logic next_burnout_sink_en;
	logic [1:0] next_channel_select;
	logic next_noise_short;
	logic [1:0] next_cal_pair;
	logic [7:0] next_mode_readback;

	// ------------------------------------------------------------
	// Field storage.
	// ------------------------------------------------------------

	// Fields load on a write and hold otherwise.
	always_comb begin
		// The two-flop chains shift one stage per edge.
		next_src_sync = {src_sync[0], clk_src_crystal};
		next_mclk_sync = {mclk_sync[0], mclk_in};
		// Without a write every field keeps its value.
		next_range_q = range_q;
		next_clock_output_disable_q = clock_output_disable_q;
		next_burnout_q = burnout_q;
		next_chan_q = chan_q;
		if (mode_wr) begin
			// The reserved zero bit is ignored; the host keeps it clear.
			next_range_q = mode_wdata[RANGE_HI:RANGE_LO];
			next_clock_output_disable_q = mode_wdata[CLOCK_OUTPUT_DISABLE_BIT];
			next_burnout_q = mode_wdata[BURNOUT_BIT];
			next_chan_q = mode_wdata[CHAN_HI:CHAN_LO];
		end
	end

	// Registers the fields; reset returns them to defaults.
	always_ff @(posedge clk) begin
		if (srst) begin
			// Fields return to their defaults.
			src_sync <= 2'h0;
			mclk_sync <= 2'h0;
			range_q <= RANGE_RESET;
			clock_output_disable_q <= 1'b0;
			burnout_q <= 1'b0;
			chan_q <= CHAN_RESET;
		end else begin
			src_sync <= next_src_sync;
			mclk_sync <= next_mclk_sync;
			range_q <= next_range_q;
			clock_output_disable_q <= next_clock_output_disable_q;
			burnout_q <= next_burnout_q;
			chan_q <= next_chan_q;
		end
	end

	// ------------------------------------------------------------
	// Output decode.
	// ------------------------------------------------------------

	// Computes every control output from the stored fields, coding and offset from their pins, clock pin and run flag also from the synchronised pins.
	always_comb begin
		// Span and output coding.
		next_input_range_select = amlfc_span_t'(range_q);
		next_unipolar_coding = polarity_unipolar;
		next_offset_applied = (offset_dac != DAC_NO_OFFSET);
		// Clock pin and conversion clock.
		next_mclk_out = clock_output_disable_q ? 1'b0 : mclk_sync[1];
		// A crystal stops with the pin; an external clock does not.
		next_conv_clock_run = !(clock_output_disable_q && src_sync[1]);
		// Both burnout currents switch together.
		next_burnout_source_en = burnout_q;
		next_burnout_sink_en = burnout_q;
		// Channel, noise test and calibration pair.
		next_channel_select = chan_q;
		next_noise_short = (chan_q == CHAN_NOISE);
		next_cal_pair = pair_of(chan_q);
		// Readback shows the stored fields; the two top bits read zero.
		next_mode_readback = 8'h00;
		next_mode_readback[RANGE_HI:RANGE_LO] = range_q;
		next_mode_readback[CLOCK_OUTPUT_DISABLE_BIT] = clock_output_disable_q;
		next_mode_readback[BURNOUT_BIT] = burnout_q;
		next_mode_readback[CHAN_HI:CHAN_LO] = chan_q;
	end

	// Registers the outputs.
	always_ff @(posedge clk) begin
		if (srst) begin
			// Outputs start in the state that the reset fields decode to.
			input_range_select <= AMLFC_SPAN_80MV;
			unipolar_coding <= 1'b0;
			offset_applied <= 1'b0;
			mclk_out <= 1'b0;
			conv_clock_run <= 1'b1;
			burnout_source_en <= 1'b0;
			burnout_sink_en <= 1'b0;
			channel_select <= CHAN_RESET;
			noise_short <= 1'b0;
			cal_pair <= CAL_PAIR0;
			mode_readback <= READBACK_RESET;
		end else begin
			// Each output follows its next value.
			input_range_select <= next_input_range_select;
			unipolar_coding <= next_unipolar_coding;
			offset_applied <= next_offset_applied;
			mclk_out <= next_mclk_out;
			conv_clock_run <= next_conv_clock_run;
			burnout_source_en <= next_burnout_source_en;
			burnout_sink_en <= next_burnout_sink_en;
			channel_select <= next_channel_select;
			noise_short <= next_noise_short;
			cal_pair <= next_cal_pair;
			mode_readback <= next_mode_readback;
		end
	end

	// ------------------------------------------------------------
	// Checks.
	// ------------------------------------------------------------

	// The stored disable bit forces the clock pin low on the next edge.
	a_clk_pin_low: assert property (@(posedge clk) disable iff (srst)
		clock_output_disable_q |=> !mclk_out) else $error("clock pin not low");

	// A written range reaches the span output two edges after the write.
	a_range_write: assert property (@(posedge clk) disable iff (srst)
		mode_wr |=> ##1 input_range_select ==
		amlfc_span_t'($past(mode_wdata[RANGE_HI:RANGE_LO], 2)))
		else $error("range not applied");

	// Reset returns the range field to the widest span.
	a_reset_range: assert property (@(posedge clk)
		srst |=> range_q == RANGE_WIDEST) else $error("range reset wrong");

	// An external clock keeps the conversion clock running.
	a_ext_clk_runs: assert property (@(posedge clk) disable iff (srst)
		!src_sync[1] |=> conv_clock_run) else $error("ext clock stopped");

	// A crystal with the pin disabled stops conversions.
	a_xtal_stops: assert property (@(posedge clk) disable iff (srst)
		src_sync[1] && clock_output_disable_q |=> !conv_clock_run) else $error("crystal ran");

	// Both burnout currents follow the stored bit one edge later.
	a_burnout_pair: assert property (@(posedge clk) disable iff (srst)
		1'b1 |=> burnout_source_en == $past(burnout_q) &&
		burnout_sink_en == $past(burnout_q)) else $error("burnout mismatch");

	// Without a write the channel field holds.
	a_chan_hold: assert property (@(posedge clk) disable iff (srst)
		!mode_wr |=> chan_q == $past(chan_q)) else $error("channel drifted");

	// The noise test code shorts the input and uses pair zero.
	a_noise_short: assert property (@(posedge clk) disable iff (srst)
		chan_q == CHAN_NOISE |=> noise_short && cal_pair == CAL_PAIR0)
		else $error("noise mode wrong");

	// Channel code three uses calibration pair two.
	a_pair_two: assert property (@(posedge clk) disable iff (srst)
		chan_q == CHAN_PAIR2 |=> cal_pair == CAL_PAIR2) else $error("pair 2 wrong");

	// The neutral offset code reports no offset applied.
	a_offset_none: assert property (@(posedge clk) disable iff (srst)
		offset_dac == DAC_NO_OFFSET |=> !offset_applied) else $error("offset wrong");

	// The unipolar pin selects straight binary coding on the next edge.
	a_coding_follow: assert property (@(posedge clk) disable iff (srst)
		polarity_unipolar |=> unipolar_coding) else $error("coding not unipolar");

endmodule // amlfc_mode_low

// ===== rtl/amlfc_pkg.sv
package amlfc_pkg;

	// ------------------------------------------------------------
	// Field layout of the low mode byte.
	// ------------------------------------------------------------
	localparam int MODE_ZERO_BIT = 6;
	localparam int RANGE_HI = 5;
	localparam int RANGE_LO = 4;
	localparam int CLOCK_OUTPUT_DISABLE_BIT = 3;
	localparam int BURNOUT_BIT = 2;
	localparam int CHAN_HI = 1;
	localparam int CHAN_LO = 0;

	// ------------------------------------------------------------
	// Reset values and codes.
	// ------------------------------------------------------------
	localparam logic [1:0] RANGE_RESET = 2'h3;
	localparam logic [1:0] RANGE_WIDEST = 2'h3;
	localparam logic [1:0] CHAN_RESET = 2'h0;
	localparam logic [1:0] CHAN_NOISE = 2'h2;
	localparam logic [1:0] CHAN_PAIR2 = 2'h3;
	localparam logic [1:0] CHAN_PAIR0 = 2'h0;
	localparam logic [1:0] CHAN_PAIR1 = 2'h1;
	localparam logic [1:0] CAL_PAIR0 = 2'h0;
	localparam logic [1:0] CAL_PAIR1 = 2'h1;
	localparam logic [1:0] CAL_PAIR2 = 2'h2;
	localparam logic [7:0] DAC_NO_OFFSET = 8'h20;
	localparam logic [7:0] READBACK_RESET = 8'h30;

	// Analog span selected by the range field.
	typedef enum logic [1:0] {
		AMLFC_SPAN_10MV,
		AMLFC_SPAN_20MV,
		AMLFC_SPAN_40MV,
		AMLFC_SPAN_80MV
	} amlfc_span_t;

endpackage

// ===== sim/adc_mode_low_field_control_bench.sv
`timescale 1ns/1ps
module adc_mode_low_field_control_bench;
	import amlfc_pkg::*;
	logic clk = 0, srst = 1, pol = 0, xtal = 0, mclk_in = 0, mode_wr;
	logic [7:0] mode_wdata, dac = 8'h20, rb;
	amlfc_span_t rng;
	logic uni, offa, mclk_out, run, bsrc, bsnk, noise, a;
	logic [1:0] ch, cal;
	int num_errors = 0, compares = 0;
	logic [1:0] cal_exp [4] = '{2'h0, 2'h1, 2'h0, 2'h2};
	amlfc_host_model amlfc_host_model_inst (.clk(clk), .mode_wr(mode_wr),
		.mode_wdata(mode_wdata));
	amlfc_mode_low amlfc_mode_low_inst (.clk(clk), .srst(srst), .mode_wr(mode_wr),
		.mode_wdata(mode_wdata), .polarity_unipolar(pol), .offset_dac(dac),
		.clk_src_crystal(xtal), .mclk_in(mclk_in), .input_range_select(rng),
		.unipolar_coding(uni), .offset_applied(offa), .mclk_out(mclk_out),
		.conv_clock_run(run), .burnout_source_en(bsrc), .burnout_sink_en(bsnk),
		.channel_select(ch), .noise_short(noise), .cal_pair(cal), .mode_readback(rb));
	// A 100 ns clock and a master clock toggling on every falling edge.
	initial begin
		forever #50 clk = ~clk;
	end
	always @(negedge clk) begin
		mclk_in <= ~mclk_in;
	end
	// Compares one value and counts it.
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Writes a byte and waits until the decoded outputs have landed.
	task automatic wr(input logic [7:0] b);
		amlfc_host_model_inst.send(b);
		@(negedge clk);
	endtask
	// Checks the reset defaults.
	task automatic t_defaults;
		chk({6'h00, rng}, {6'h00, RANGE_WIDEST});
		chk(rb, 8'h30);
		chk({6'h00, bsrc, bsnk}, 8'h00);
		chk({6'h00, ch}, 8'h00);
		chk({7'h00, run}, 8'h01);
	endtask
	// Walks all channel codes with ranges and burnout.
	task automatic t_channels;
		for (int i = 0; i < 4; i++) begin
			wr({2'h1, i[1:0], 1'h0, i[0], i[1:0]});
			repeat (3) @(negedge clk);
			chk({6'h00, rng}, 8'(i));
			chk({6'h00, ch}, 8'(i));
			chk({7'h00, noise}, 8'(i == 2));
			chk({6'h00, cal}, {6'h00, cal_exp[i]});
			chk({6'h00, bsrc, bsnk}, {6'h00, {2{i[0]}}});
			chk(rb, {2'h0, i[1:0], 1'h0, i[0], i[1:0]});
		end
	endtask
	// Clock output disable with both clock sources.
	task automatic t_clock;
		wr(8'h38);
		for (int i = 0; i < 4; i++) begin
			@(negedge clk);
			chk({7'h00, mclk_out}, 8'h00);
			chk({7'h00, run}, 8'h01);
		end
		xtal = 1'h1;
		repeat (4) @(negedge clk);
		chk({7'h00, run}, 8'h00);
		xtal = 1'h0;
		wr(8'h30);
		repeat (5) @(negedge clk);
		// Conversions resume once the disable bit clears.
		chk({7'h00, run}, 8'h01);
		a = mclk_out;
		@(negedge clk);
		chk({7'h00, mclk_out}, {7'h00, ~a});
	endtask
	// Polarity coding and offset detection.
	task automatic t_levels;
		pol = 1'h1;
		dac = 8'h21;
		repeat (2) @(negedge clk);
		chk({6'h00, uni, offa}, 8'h03);
		pol = 1'h0;
		dac = DAC_NO_OFFSET;
		repeat (2) @(negedge clk);
		chk({6'h00, uni, offa}, 8'h00);
	endtask
	// Prints the counts and the verdict, then stops.
	task automatic conclude;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Cuts a hang short.
	initial begin
		repeat (3000) @(posedge clk);
		num_errors++;
		conclude;
	end
	// Main sequence, with a second reset after the tests and a final defaults check.
	initial begin
		repeat (4) @(negedge clk);
		srst = 1'h0;
		t_defaults;
		t_channels;
		t_clock;
		t_levels;
		// Leave non-default fields so the second reset has work to do.
		wr(8'h17);
		srst = 1'h1;
		repeat (2) @(negedge clk);
		srst = 1'h0;
		@(negedge clk);
		t_defaults;
		conclude;
	end
endmodule // adc_mode_low_field_control_bench

// ===== sim/amlfc_host_model.sv
`timescale 1ns/1ps
module amlfc_host_model (
	// Clock seen by the host.
	input wire logic clk,
	// Mode byte write towards the block.
	output logic mode_wr,
	output logic [7:0] mode_wdata
);
	// The lines start idle.
	initial begin
		mode_wr = 1'h0;
		mode_wdata = 8'h00;
	end
	// Sends one byte for one cycle, called just after a falling edge.
	task automatic send(input logic [7:0] b);
		mode_wr = 1'h1;
		mode_wdata = b & 8'hBF;
		@(negedge clk);
		mode_wr = 1'h0;
		// Released data shows its inverse, so stale bytes cannot match.
		mode_wdata = ~mode_wdata;
	endtask
endmodule // amlfc_host_model
